// File: rtl/lpf_regs.vh
`ifndef LPF_REGS_VH
`define LPF_REGS_VH

// mode encodings
`define LPF_ST_ACTIVE 2'h0
`define LPF_ST_FROZEN 2'h1
`define LPF_ST_IDLE 2'h2
// freeze entry/exit limit in ns and clock period in ns
`define LPF_FREEZE_LIMIT_NS 1000
`define LPF_CLK_PERIOD_NS 10
// longest time rounds down
`define LPF_FREEZE_LIMIT_CYC (`LPF_FREEZE_LIMIT_NS / `LPF_CLK_PERIOD_NS)
`define LPF_CNT_W 7
// input synchroniser depth
`define LPF_SYNC_W 3
// reset levels: request pins idle low, the active-low pll shutdown idles high
`define LPF_REQ_IDLE 1'h0
`define LPF_PD_IDLE 1'h1
`define LPF_FLAG_CLR 1'h0
`define LPF_FLAG_SET 1'h1
`define LPF_PAD_RST 8'h00
`define LPF_CNT_ZERO 7'h00
`define LPF_CNT_ONE 7'h01

`endif

// File: rtl/lpf_freeze_ctrl.v
// How it works
// (RULE1) asserting freeze_request_pin freezes the device and releasing it resumes, each well within 1 us.
// (RULE2) while frozen the core state enable is low so registers and sram hold their contents.
// (RULE3) when io retention is enabled the pad outputs hold their values throughout freeze.
// (RULE4) the outside may keep clocking and toggling inputs during freeze without disturbing held state.
// (RULE5) entering freeze gates off every pll-derived clock while external clocks are ignored.
// (RULE6) when incoming clocks stop the state is kept and work resumes when they restart.
// (RULE7) driving pll_shutdown_n low shuts off the pll and its output clocks; the code keeps the pll powered while want_freeze is high, as freeze wins.
// (RULE8) in static idle nothing changes state.
// (RULE9) in the qualified variant freeze needs both the request and freeze_qualify_signal; dropping the request resumes.
`timescale 1ns/100ps
`default_nettype none
`include "lpf_regs.vh"

module lpf_freeze_ctrl (
	input wire clk,
	input wire reset,
	input wire freeze_request_pin,
	input wire freeze_qualify_signal,
	input wire pll_shutdown_n,
	input wire qualify_mode,
	input wire io_retain_en,
	input wire [7:0] io_out_core,
	output reg [7:0] io_out_pad,
	output wire core_state_en,
	output reg pll_clk_en,
	output reg pll_power_en,
	output reg frozen,
	output reg static_idle,
	output reg [1:0] mode,
	output reg deadline_miss
);

	wire req_r;
	wire qual_r;
	wire pd_n_r;
	reg [`LPF_CNT_W-1:0] lat_cnt_r;
	reg [`LPF_CNT_W-1:0] lat_cnt_nxt;
	reg want_freeze;
	reg [1:0] mode_nxt;
	reg frozen_nxt;
	reg static_idle_nxt;
	reg pll_clk_en_nxt;
	reg pll_power_en_nxt;
	reg pad_hold;

	// each pin has its own synchroniser; the shutdown pin resets high so reset never fakes an idle request
	lpf_sync #(
		.RST_VAL(`LPF_REQ_IDLE)
	) i_req_sync (
		.clk(clk),
		.reset(reset),
		.pin_in(freeze_request_pin),
		.level_r(req_r)
	);

	lpf_sync #(
		.RST_VAL(`LPF_REQ_IDLE)
	) i_qual_sync (
		.clk(clk),
		.reset(reset),
		.pin_in(freeze_qualify_signal),
		.level_r(qual_r)
	);

	lpf_sync #(
		.RST_VAL(`LPF_PD_IDLE)
	) i_pd_sync (
		.clk(clk),
		.reset(reset),
		.pin_in(pll_shutdown_n),
		.level_r(pd_n_r)
	);

	// exit only needs the request dropped; qualify matters at entry only
	always @* begin
		if (qualify_mode) begin
			want_freeze = req_r & (qual_r | (mode == `LPF_ST_FROZEN)); // see (RULE9)
		end else begin
			want_freeze = req_r; // see (RULE1)
		end
	end

	always @* begin
		mode_nxt = mode;
		case (mode)
			`LPF_ST_ACTIVE: begin
				if (want_freeze)
					mode_nxt = `LPF_ST_FROZEN;
				else if (!pd_n_r)
					mode_nxt = `LPF_ST_IDLE; // see (RULE7)
			end
			`LPF_ST_FROZEN: begin
				if (!want_freeze)
					mode_nxt = `LPF_ST_ACTIVE; // see (RULE1)
			end
			`LPF_ST_IDLE: begin
				if (want_freeze)
					mode_nxt = `LPF_ST_FROZEN;
				else if (pd_n_r)
					mode_nxt = `LPF_ST_ACTIVE;
			end
			default: mode_nxt = `LPF_ST_ACTIVE;
		endcase
	end

	always @* begin
		frozen_nxt = (mode_nxt == `LPF_ST_FROZEN);
		static_idle_nxt = (mode_nxt == `LPF_ST_IDLE);
		// pll clocks gated in freeze, pll itself off in idle
		pll_clk_en_nxt = (mode_nxt == `LPF_ST_ACTIVE); // see (RULE5)
		pll_power_en_nxt = (mode_nxt != `LPF_ST_IDLE); // see (RULE7)
		pad_hold = frozen && io_retain_en;
	end

	always @(posedge clk) begin
		if (reset) begin
			mode <= `LPF_ST_ACTIVE;
		end else begin
			mode <= mode_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			frozen <= `LPF_FLAG_CLR;
		end else begin
			frozen <= frozen_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			static_idle <= `LPF_FLAG_CLR;
		end else begin
			static_idle <= static_idle_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			pll_clk_en <= `LPF_FLAG_SET;
		end else begin
			pll_clk_en <= pll_clk_en_nxt; // see (RULE5)
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			pll_power_en <= `LPF_FLAG_SET;
		end else begin
			pll_power_en <= pll_power_en_nxt; // see (RULE7)
		end
	end

	// held low in freeze and idle so no core flop or sram write can land; clock stopping needs nothing extra
	assign core_state_en = (mode == `LPF_ST_ACTIVE); // see (RULE2) see (RULE4) see (RULE6) see (RULE8)

	// pads keep following the core except in freeze with retention strapped on
	always @(posedge clk) begin
		if (reset) begin
			io_out_pad <= `LPF_PAD_RST;
		end else if (!pad_hold) begin
			io_out_pad <= io_out_core; // see (RULE3)
		end
	end

	// watchdog on transition latency, sticky until reset
	always @* begin
		lat_cnt_nxt = `LPF_CNT_ZERO;
		if ((want_freeze != (mode == `LPF_ST_FROZEN)) && !deadline_miss)
			lat_cnt_nxt = lat_cnt_r + `LPF_CNT_ONE;
	end

	always @(posedge clk) begin
		if (reset) begin
			lat_cnt_r <= `LPF_CNT_ZERO;
		end else begin
			lat_cnt_r <= lat_cnt_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			deadline_miss <= `LPF_FLAG_CLR;
		end else if (lat_cnt_r >= `LPF_FREEZE_LIMIT_CYC) begin
			deadline_miss <= `LPF_FLAG_SET; // see (RULE1)
		end
	end

endmodule

// three-flop synchroniser with a two-sample agreement filter
module lpf_sync #(
	parameter [0:0] RST_VAL = 1'h0
) (
	input wire clk,
	input wire reset,
	input wire pin_in,
	output reg level_r
);

	reg [`LPF_SYNC_W-1:0] stage_r;
	wire [`LPF_SYNC_W-1:0] stage_nxt;
	wire settled;

	// stage one may be metastable; only stage two reads it
	assign stage_nxt = {stage_r[`LPF_SYNC_W-2:0], pin_in};

	// a level that has not stood for two samples is a glitch and is dropped
	assign settled = (stage_r[`LPF_SYNC_W-2] == stage_r[`LPF_SYNC_W-1]);

	always @(posedge clk) begin
		if (reset) begin
			stage_r <= {`LPF_SYNC_W{RST_VAL}};
		end else begin
			stage_r <= stage_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			level_r <= RST_VAL;
		end else if (settled) begin
			level_r <= stage_r[`LPF_SYNC_W-1];
		end
	end

endmodule
`default_nettype wire

// File: tb/lpf_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module lpf_ctl_model (input wire clk, input wire [2:0] cmd, output logic freeze_request_pin = 1'b0,
	output logic freeze_qualify_signal = 1'b0, output logic pll_shutdown_n = 1'b1);
	// pins move only on clk edges, so the far side never glitches a request
	always @(posedge clk) begin
		freeze_request_pin <= cmd[0];
		freeze_qualify_signal <= cmd[1];
		pll_shutdown_n <= !cmd[2];
	end
endmodule
`default_nettype wire

// File: tb/lpf_freeze_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module lpf_sva (input wire clk, reset, freeze_request_pin, freeze_qualify_signal, qualify_mode, io_retain_en,
	input wire [7:0] io_out_pad, input wire core_state_en, pll_clk_en, pll_power_en, frozen, static_idle, deadline_miss);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_on; $rose(freeze_request_pin) && !qualify_mode ##1 freeze_request_pin [*8]; endsequence
	sequence s_off; $fell(freeze_request_pin) ##1 !freeze_request_pin [*8]; endsequence
	a_frz_in: assert property (s_on |-> ##[0:91] frozen) else $error("late freeze");
	a_frz_out: assert property (s_off |-> ##[0:91] !frozen) else $error("late resume");
	a_core_hold: assert property (frozen || static_idle |-> !core_state_en) else $error("core on");
	a_pad_hold: assert property (frozen && $past(frozen, 2) && io_retain_en |-> $stable(io_out_pad))
		else $error("pad moved");
	a_pll_gate: assert property (frozen |-> !pll_clk_en) else $error("pll clock on");
	a_pll_off: assert property (static_idle |-> !pll_power_en) else $error("pll powered");
	a_qual_gate: assert property ((qualify_mode && !freeze_qualify_signal && !frozen) [*8] |=> !frozen)
		else $error("bad freeze");
	a_no_miss: assert property (!deadline_miss) else $error("slow change");
endmodule
bind lpf_freeze_ctrl lpf_sva i_sva(.clk(clk), .reset(reset), .freeze_request_pin(freeze_request_pin),
	.freeze_qualify_signal(freeze_qualify_signal), .qualify_mode(qualify_mode), .io_retain_en(io_retain_en),
	.io_out_pad(io_out_pad), .core_state_en(core_state_en), .pll_clk_en(pll_clk_en), .pll_power_en(pll_power_en),
	.frozen(frozen), .static_idle(static_idle), .deadline_miss(deadline_miss));
`default_nettype wire

// File: tb/test_low_power_freeze_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_low_power_freeze_control;
	logic clk = 0, reset = 1, qualify_mode = 0, io_retain_en = 1;
	logic [2:0] cmd = 3'h0;
	logic [7:0] io_out_core = 8'h5a, io_out_pad;
	logic [1:0] mode;
	logic freeze_request_pin, freeze_qualify_signal, pll_shutdown_n, core_state_en, pll_clk_en;
	logic pll_power_en, frozen, static_idle, deadline_miss;
	int n_fail = 0, check_count = 0;
	always #5 clk = ~clk;
	lpf_ctl_model i_ctl(.clk(clk), .cmd(cmd), .freeze_request_pin(freeze_request_pin),
		.freeze_qualify_signal(freeze_qualify_signal), .pll_shutdown_n(pll_shutdown_n));
	lpf_freeze_ctrl i_dut(.clk(clk), .reset(reset), .freeze_request_pin(freeze_request_pin),
		.freeze_qualify_signal(freeze_qualify_signal), .pll_shutdown_n(pll_shutdown_n),
		.qualify_mode(qualify_mode), .io_retain_en(io_retain_en), .io_out_core(io_out_core),
		.io_out_pad(io_out_pad), .core_state_en(core_state_en), .pll_clk_en(pll_clk_en),
		.pll_power_en(pll_power_en), .frozen(frozen), .static_idle(static_idle), .mode(mode),
		.deadline_miss(deadline_miss));
	task end_sim;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task ck(input logic b);
		check_count++;
		if (b !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t mode %0h", $time, mode);
		end
	endtask
	// bounded wait for a mode; running out ends the run
	task w(input logic [1:0] m);
		for (int i = 0; i < 100 && mode !== m; i++) @(posedge clk) #1;
		ck(mode === m);
		if (mode !== m) end_sim;
	endtask
	// r selects pad retention; without it the pads must keep following the core
	task t_frz(input logic q, input logic r);
		@(posedge clk) qualify_mode <= q;
		io_retain_en <= r;
		cmd <= {1'b0, q, 1'b1};
		w(2'h1);
		ck(!pll_clk_en && !core_state_en && frozen);
		@(posedge clk) io_out_core <= ~io_out_core;
		repeat (3) @(posedge clk) #1;
		ck(io_out_pad === (r ? ~io_out_core : io_out_core));
		@(posedge clk) cmd <= {1'b0, q, 1'b0};
		w(2'h0);
		repeat (3) @(posedge clk) #1;
		ck(io_out_pad === io_out_core && pll_clk_en);
		$display("freeze test %0d end", q);
	endtask
	task t_ref;
		@(posedge clk) cmd <= 3'h1;
		repeat (20) @(posedge clk) #1;
		ck(mode === 2'h0);
		@(posedge clk) cmd <= 3'h0;
		$display("refuse test end");
	endtask
	task t_idl;
		@(posedge clk) cmd <= 3'h4;
		w(2'h2);
		ck(!pll_power_en && !pll_clk_en && static_idle && !core_state_en);
		@(posedge clk) cmd <= 3'h0;
		w(2'h0);
		$display("idle test end");
	endtask
	// reset in mid-freeze: reset levels, then the still-high request must freeze again
	task t_rst;
		@(posedge clk) qualify_mode <= 1'b0;
		io_retain_en <= 1'b1;
		cmd <= 3'h1;
		w(2'h1);
		@(posedge clk) reset <= 1'b1;
		repeat (2) @(posedge clk) #1;
		ck(mode === 2'h0 && !frozen && !static_idle && pll_clk_en && pll_power_en && core_state_en);
		ck(io_out_pad === 8'h00 && deadline_miss === 1'b0);
		@(posedge clk) reset <= 1'b0;
		w(2'h1);
		@(posedge clk) cmd <= 3'h0;
		w(2'h0);
		$display("reset test end");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 0;
		t_frz(0, 1);
		t_frz(1, 0);
		t_ref;
		t_idl;
		t_rst;
		ck(deadline_miss === 1'b0);
		end_sim;
	end
endmodule
`default_nettype wire
